// file: hw/lbt_pkg.sv
package lbt_pkg;
	// Width of one transceiver slice: eight data bits and a parity bit.
	localparam int unsigned WORD_WIDTH = 9;
	// Depth of the capture log buffer.
	localparam int unsigned LOG_DEPTH = 2;
	// Stages of the pin synchroniser.
	localparam int unsigned SYNC_STAGES = 3;
	// Register byte offsets.
	localparam logic [7:0] CTRL_OFFSET   = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] LOG_OFFSET    = 8'h08;
	// Field positions.
	localparam int unsigned CTRL_SOFT_OFF_BIT = 0;
	localparam int unsigned STATUS_DRV_LSB    = 0;
	localparam int unsigned STATUS_RX_LSB     = 16;
	localparam int unsigned LOG_VALID_BIT     = 31;
	// Reset values.
	localparam logic CTRL_SOFT_OFF_RESET = 1'b0;
	localparam logic CLK_LEVEL_RESET     = 1'b0;
endpackage : lbt_pkg

// file: hw/lbt_pin_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser for one asynchronous pin.
module lbt_pin_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic pin,
	output logic      stage_two,
	output logic      stage_three
);
	logic stage_one;

	// The first stage feeds only the second one.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_one   <= 1'b0;
			stage_two   <= 1'b0;
			stage_three <= 1'b0;
		end else begin
			stage_one   <= pin;
			stage_two   <= stage_one;
			stage_three <= stage_two;
		end
	end
endmodule : lbt_pin_sync

// file: hw/lbt_log_fifo.sv
`timescale 1ns/1ps
// Small first-word-fall-through buffer with valid and ready on both sides.
module lbt_log_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 2
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic [PW-1:0]    next_wr_ptr;
	logic [PW-1:0]    next_rd_ptr;
	logic [PW:0]      next_count;
	logic             push;
	logic             pop;

	// Full and empty come straight from the fill count.
	assign in_ready  = (count != (PW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	// Pointer and count next values.
	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count  = count;
		if (push) begin
			next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
		end
		if (push && !pop) begin
			next_count = (PW+1)'(count + 1'b1);
		end else if (pop && !push) begin
			next_count = (PW+1)'(count - 1'b1);
		end
	end

	// Pointer registers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// Storage words are written only on a push.
	always_ff @(posedge pclk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule : lbt_log_fifo

// file: hw/lbt_transceiver.sv
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// How it works
// - A high bus_side_off floats every logic-side pin and releases every backplane pin.
// - direction_transmit high sends logic side to backplane, low receives into the logic side.
// - Transmit with driver_register_skip high pulls each backplane bit low where its logic pin is high.
// - Transmit with the skip low drives the backplane from the driver register, held between edges.
// - The driver register takes all nine logic pins on each rising capture clock edge.
// - Receive with receive_latch_open high shows the inverse of each backplane pin.
// - When the latch closes the logic side keeps the last value shown while it was open.
// - The skip only routes around the driver register and never disturbs its contents.
module lbt_transceiver (
	input  wire logic                               pclk,
	input  wire logic                               presetn,
	input  wire logic                               psel,
	input  wire logic                               penable,
	input  wire logic                               pwrite,
	input  wire logic [7:0]                         paddr,
	input  wire logic [31:0]                        pwdata,
	output logic      [31:0]                        prdata,
	output logic                                    pready,
	output logic                                    pslverr,
	input  wire logic                               bus_side_off,
	input  wire logic                               direction_transmit,
	input  wire logic                               receive_latch_open,
	input  wire logic                               driver_register_skip,
	input  wire logic                               capture_clock,
	input  wire logic [lbt_pkg::WORD_WIDTH-1:0]     logic_side_pins_in,
	output logic      [lbt_pkg::WORD_WIDTH-1:0]     logic_side_pins_out,
	output logic      [lbt_pkg::WORD_WIDTH-1:0]     logic_side_pins_oe,
	input  wire logic [lbt_pkg::WORD_WIDTH-1:0]     backplane_pins_in,
	output logic      [lbt_pkg::WORD_WIDTH-1:0]     backplane_pins_out,
	output logic      [lbt_pkg::WORD_WIDTH-1:0]     backplane_pins_oe,
	output logic                                    capture_log_ready
);
	localparam int unsigned W = lbt_pkg::WORD_WIDTH;

	// Control register and its next value.
	logic          soft_off;
	logic          next_soft_off;

	// Capture clock synchroniser and edge detect.
	logic          clk_level;
	logic          next_clk_level;
	logic          clk_s2;
	logic          clk_s3;
	logic          cap_edge;

	// Stored words of the two data paths.
	logic [W-1:0]  drv_reg;
	logic [W-1:0]  next_drv_reg;
	logic [W-1:0]  rx_hold;
	logic [W-1:0]  next_rx_hold;

	// Direction and disable decode.
	logic          off;
	logic          tx_on;
	logic          rx_on;
	logic [W-1:0]  tx_word;

	// Capture log and register bus.
	logic          log_in_ready;
	logic          log_valid;
	logic          log_pop;
	logic [W-1:0]  log_data;
	logic          access;
	logic          addr_ok;
	logic [31:0]   rd_word;
	logic [31:0]   next_prdata;

	// Capture clock pin crosses into pclk through three flip-flops.
	lbt_pin_sync u_clk_sync (
		.pclk        (pclk),
		.presetn     (presetn),
		.pin         (capture_clock),
		.stage_two   (clk_s2),
		.stage_three (clk_s3)
	);

	// A level change counts only once stages two and three agree.
	always_comb begin
		next_clk_level = (clk_s2 == clk_s3) ? clk_s3 : clk_level;
	end

	assign cap_edge = next_clk_level && !clk_level; // Rising capture edge.

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_level <= lbt_pkg::CLK_LEVEL_RESET;
		end else begin
			clk_level <= next_clk_level;
		end
	end

	// Driver register loads only on a capture edge; the skip never touches it.
	always_comb begin
		next_drv_reg = drv_reg;
		if (cap_edge) begin
			next_drv_reg = logic_side_pins_in;
		end
	end

	// Receive latch tracks the inverted bus while open and holds once closed.
	always_comb begin
		next_rx_hold = rx_hold;
		if (receive_latch_open) begin
			next_rx_hold = ~backplane_pins_in;
		end
	end

	// Data holders have no reset, like the pin-level part.
	always_ff @(posedge pclk) begin
		drv_reg <= next_drv_reg;
		rx_hold <= next_rx_hold;
	end

	// Direction and disable decode, level functions of the control pins.
	assign off   = bus_side_off || soft_off;
	assign tx_on = !off && direction_transmit;
	assign rx_on = !off && !direction_transmit;

	// Transmit word: fall-through pins or the stored register.
	assign tx_word = driver_register_skip ? logic_side_pins_in : drv_reg;

	// Open-drain backplane: a high word bit pulls the wire low, otherwise it floats high.
	assign backplane_pins_out = '0;
	assign backplane_pins_oe  = tx_on ? tx_word : '0;

	// Logic side drives only in receive; transparent while open, held once closed.
	assign logic_side_pins_oe  = {W{rx_on}};
	assign logic_side_pins_out = receive_latch_open ? ~backplane_pins_in : rx_hold;

	// Every captured word is offered to the log; its ready is a block port.
	lbt_log_fifo #(
		.WIDTH (W),
		.DEPTH (lbt_pkg::LOG_DEPTH)
	) u_log (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_valid  (cap_edge),
		.in_ready  (log_in_ready),
		.in_data   (logic_side_pins_in),
		.out_valid (log_valid),
		.out_ready (log_pop),
		.out_data  (log_data)
	);

	assign capture_log_ready = log_in_ready;

	// APB decode: zero wait states, unmapped addresses answer with an error.
	assign access  = psel && penable;
	assign addr_ok = (paddr == lbt_pkg::CTRL_OFFSET) || (paddr == lbt_pkg::STATUS_OFFSET)
		|| (paddr == lbt_pkg::LOG_OFFSET);
	assign pready  = 1'b1;
	assign pslverr = access && !addr_ok;
	assign log_pop = access && !pwrite && (paddr == lbt_pkg::LOG_OFFSET) && log_valid;

	// Read mux, reserved bits read as zero.
	always_comb begin
		rd_word = '0;
		case (paddr)
			lbt_pkg::CTRL_OFFSET: begin
				rd_word[lbt_pkg::CTRL_SOFT_OFF_BIT] = soft_off;
			end
			lbt_pkg::STATUS_OFFSET: begin
				rd_word[lbt_pkg::STATUS_DRV_LSB +: W] = drv_reg;
				rd_word[lbt_pkg::STATUS_RX_LSB +: W]  = rx_hold;
			end
			lbt_pkg::LOG_OFFSET: begin
				rd_word[lbt_pkg::LOG_VALID_BIT] = log_valid;
				rd_word[W-1:0]                  = log_valid ? log_data : '0;
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	// Control register write.
	always_comb begin
		next_soft_off = soft_off;
		if (access && pwrite && (paddr == lbt_pkg::CTRL_OFFSET)) begin
			next_soft_off = pwdata[lbt_pkg::CTRL_SOFT_OFF_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			soft_off <= lbt_pkg::CTRL_SOFT_OFF_RESET;
		end else begin
			soft_off <= next_soft_off;
		end
	end

	// Read data is taken at the end of the setup phase, so it stands through the access phase.
	always_comb begin
		next_prdata = '0;
		if (psel && !penable && !pwrite) begin
			next_prdata = rd_word;
		end
	end

	// Read data register; it returns to zero once the access phase is over.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else begin
			prdata <= next_prdata;
		end
	end

	// All checks below run on the register clock and rest while reset is low.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// A disabled slice lets every backplane wire float high.
	a_off_release: assert property (
		off |-> backplane_pins_oe == '0)
		else $error("Backplane driven while disabled.");

	// A disabled slice floats the logic side.
	a_off_logic_float: assert property (
		off |-> logic_side_pins_oe == '0)
		else $error("Logic side driven while disabled.");

	// Receive drives only the logic side.
	a_dir_receive: assert property (
		rx_on |-> backplane_pins_oe == '0 && &logic_side_pins_oe)
		else $error("Receive direction drives the wrong side.");

	// Transmit never drives the logic side.
	a_tx_logic_float: assert property (
		tx_on |-> logic_side_pins_oe == '0)
		else $error("Transmit direction drives the logic side.");

	// Fall-through pulls a wire low exactly where its logic pin is high.
	a_skip_fall_through: assert property (
		tx_on && driver_register_skip |-> backplane_pins_oe == logic_side_pins_in)
		else $error("Fall-through transmit does not follow the logic pins.");

	// Registered transmit shows the stored word.
	a_reg_drive_bus: assert property (
		tx_on && !driver_register_skip |-> backplane_pins_oe == drv_reg)
		else $error("Registered transmit does not show the driver register.");

	// The stored word only moves on a capture edge.
	a_reg_hold_value: assert property (
		!cap_edge |=> $stable(drv_reg))
		else $error("Driver register changed without a capture edge.");

	// A capture edge loads the logic pins of that cycle.
	a_capture_edge_load: assert property (
		cap_edge |=> drv_reg == $past(logic_side_pins_in))
		else $error("Capture edge did not load the logic pins.");

	// A held capture clock rise is seen after the synchroniser delay.
	a_sync_edge_delay: assert property (
		$rose(capture_clock) ##1 capture_clock [*3] |-> ##[0:1] cap_edge)
		else $error("Capture edge not seen within the synchroniser delay.");

	// An open latch shows the inverted bus.
	a_rx_follow_bus: assert property (
		receive_latch_open |-> logic_side_pins_out == ~backplane_pins_in)
		else $error("Open latch does not follow the inverted bus.");

	// A closed latch keeps its value whatever the bus does.
	a_rx_latch_hold: assert property (
		!receive_latch_open && $past(!receive_latch_open) |-> $stable(logic_side_pins_out))
		else $error("Closed latch output moved.");

	// Closing the latch keeps the value shown while it was open.
	a_rx_close_keep: assert property (
		$fell(receive_latch_open) |-> logic_side_pins_out == $past(logic_side_pins_out))
		else $error("Latch lost its value on closing.");

	// The skip leaves the stored word alone.
	a_skip_no_disturb: assert property (
		driver_register_skip && !cap_edge |=> $stable(drv_reg))
		else $error("Skip disturbed the driver register.");

	// A full log always has a word to offer.
	a_log_full_flag: assert property (
		!capture_log_ready |-> log_valid)
		else $error("Log refuses words while empty.");

	// A capture accepted by the log leaves it holding a word.
	a_capture_logged: assert property (
		cap_edge && capture_log_ready |=> log_valid)
		else $error("Accepted capture missing from the log.");

	// Read data of a setup cycle stands in the access phase.
	a_read_data_stands: assert property (
		psel && !penable && !pwrite |=> prdata == $past(rd_word))
		else $error("Read data not presented in the access phase.");

	// Outside a read access the data lines rest at zero.
	a_idle_read_zero: assert property (
		!(psel && !penable && !pwrite) |=> prdata == '0)
		else $error("Read data not cleared outside a read.");

	// An unmapped read answers with an error and zero data.
	a_unmapped_read: assert property (
		access && !addr_ok && !pwrite |-> pslverr && prdata == '0)
		else $error("Unmapped read not refused.");

	// Main scenarios worth seeing at least once.
	c_fall_through: cover property (tx_on && driver_register_skip && |logic_side_pins_in);
	c_reg_transmit: cover property (cap_edge ##1 tx_on && !driver_register_skip);
	c_latch_close: cover property (rx_on && $fell(receive_latch_open));
	c_log_full: cover property (!capture_log_ready);
	c_log_pop: cover property (log_pop);
endmodule : lbt_transceiver

// file: test/lbt_bus_partner.sv
`timescale 1ns/1ps
// Wired-OR backplane with a pull-up shared by the block and the other cards.
module lbt_bus_partner (
	input  wire logic [8:0] dut_oe,
	input  wire logic [8:0] dut_out,
	input  wire logic [8:0] other_pull,
	output logic      [8:0] level
);
	// A wire is low while any party pulls it, and goes back high once all release it.
	assign level = ~((dut_oe & ~dut_out) | other_pull);
endmodule : lbt_bus_partner

// file: test/testbench.sv
`timescale 1ns/1ps
// Drives the transceiver slice through its pins and registers and judges the results.
module testbench;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        off = 1'b0;
	logic        dir = 1'b0;
	logic        latch_open = 1'b0;
	logic        skip = 1'b0;
	logic        cclk = 1'b0;
	logic [8:0]  tb_a = 9'h000;
	logic [8:0]  other = 9'h000;
	logic [8:0]  a_out;
	logic [8:0]  a_oe;
	logic [8:0]  a_level;
	logic [8:0]  b_out;
	logic [8:0]  b_oe;
	logic [8:0]  b_level;
	logic        log_rdy;
	logic [31:0] rd;
	logic        err;
	logic [8:0]  pats [4] = '{9'h000, 9'h1ff, 9'h0a5, 9'h15a};
	int          mismatches = 0;
	int          checks_done = 0;

	// Clock of 50 ns period.
	always #25 pclk = ~pclk;
	// The logic-side wire carries the block's drive while enabled, else the bench's.
	assign a_level = (a_oe & a_out) | (~a_oe & tb_a);

	lbt_transceiver lbt_transceiver_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus_side_off(off), .direction_transmit(dir),
		.receive_latch_open(latch_open), .driver_register_skip(skip), .capture_clock(cclk),
		.logic_side_pins_in(a_level), .logic_side_pins_out(a_out),
		.logic_side_pins_oe(a_oe), .backplane_pins_in(b_level), .backplane_pins_out(b_out),
		.backplane_pins_oe(b_oe), .capture_log_ready(log_rdy));
	lbt_bus_partner lbt_bus_partner_inst (.dut_oe(b_oe), .dut_out(b_out),
		.other_pull(other), .level(b_level));

	task give_verdict;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
			mismatches++;
		end
	endtask : check_word

	task check_pins(input string name, input logic [8:0] exp, input logic [8:0] got);
		check_word(name, {23'h0, exp}, {23'h0, got});
	endtask : check_pins

	// One APB transfer; read data and error are taken at the edge that sees pready.
	task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			mismatches++;
			give_verdict();
		end
	endtask : apb

	// One capture clock pulse with the logic pins held well past the rising edge.
	task capture(input logic [8:0] w);
		tb_a <= w;
		@(posedge pclk);
		cclk <= 1'b1;
		repeat (4) @(posedge pclk);
		cclk <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : capture

	task test_regs;
		dir <= 1'b1;
		skip <= 1'b1;
		tb_a <= 9'h1ff;
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b0, 8'h00, 32'h0);
		check_word("ctrl", 32'h1, rd & 32'h1);
		check_pins("soft off bus", 9'h1ff, b_level);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b0, 8'h0c, 32'h0);
		check_word("unmapped err", 32'h1, {31'h0, err});
		check_word("unmapped data", 32'h0, rd);
		$display("test_regs done");
	endtask : test_regs

	task test_off;
		off <= 1'b1;
		other <= 9'h000;
		for (int i = 0; i < 4; i++) begin
			dir <= i[0];
			skip <= i[1];
			latch_open <= 1'b1;
			@(negedge pclk);
			check_pins("off logic oe", 9'h000, a_oe);
			check_pins("off bus", 9'h1ff, b_level);
			@(posedge pclk);
		end
		off <= 1'b0;
		$display("test_off done");
	endtask : test_off

	task test_fall;
		dir <= 1'b1;
		skip <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			tb_a <= pats[i];
			@(negedge pclk);
			check_pins("fall bus", ~pats[i], b_level);
			check_pins("tx logic oe", 9'h000, a_oe);
			@(posedge pclk);
		end
		$display("test_fall done");
	endtask : test_fall

	task test_capture;
		capture(pats[2]);
		skip <= 1'b0;
		@(negedge pclk);
		check_pins("captured bus", ~pats[2], b_level);
		check_word("log room", 32'h1, {31'h0, log_rdy});
		@(posedge pclk);
		tb_a <= pats[3];
		@(negedge pclk);
		check_pins("held bus", ~pats[2], b_level);
		@(posedge pclk);
		skip <= 1'b1;
		@(negedge pclk);
		check_pins("skip bus", ~pats[3], b_level);
		@(posedge pclk);
		skip <= 1'b0;
		@(negedge pclk);
		check_pins("restored bus", ~pats[2], b_level);
		apb(1'b0, 8'h04, 32'h0);
		check_pins("status drv", pats[2], rd[8:0]);
		capture(pats[3]);
		check_word("log full", 32'h0, {31'h0, log_rdy});
		capture(9'h033);
		check_pins("third capture", ~9'h033, b_level);
		apb(1'b0, 8'h08, 32'h0);
		check_word("log first", {23'h400000, pats[2]}, rd & 32'h800001ff);
		@(negedge pclk);
		check_word("log room back", 32'h1, {31'h0, log_rdy});
		apb(1'b0, 8'h08, 32'h0);
		check_word("log second", {23'h400000, pats[3]}, rd & 32'h800001ff);
		apb(1'b0, 8'h08, 32'h0);
		check_word("log empty", 32'h0, rd & 32'h80000000);
		$display("test_capture done");
	endtask : test_capture

	task test_receive;
		dir <= 1'b0;
		latch_open <= 1'b1;
		other <= pats[2];
		@(negedge pclk);
		check_pins("rx open", pats[2], a_out);
		check_pins("rx logic oe", 9'h1ff, a_oe);
		@(posedge pclk);
		other <= pats[3];
		@(negedge pclk);
		check_pins("rx follow", pats[3], a_out);
		@(posedge pclk);
		latch_open <= 1'b0;
		@(posedge pclk);
		other <= pats[1];
		@(negedge pclk);
		check_pins("rx held", pats[3], a_out);
		apb(1'b0, 8'h04, 32'h0);
		check_pins("status rx", pats[3], rd[24:16]);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check_pins("rx after reset", pats[3], a_out);
		$display("test_receive done");
	endtask : test_receive

	// Main sequence: reset for ten cycles, then each scenario in turn.
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		test_regs();
		test_off();
		test_fall();
		test_capture();
		test_receive();
		give_verdict();
	end
endmodule : testbench
